/* File: rtl/ebwih_pkg.sv */
// Constants and types shared by the external bus cycle controller.
// Assumes a 32-bit register address and 16-bit register data.
package ebwih_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [31:0] ADDR_AWT = 32'hfffff488;
    localparam logic [31:0] ADDR_IDC = 32'hfffff48a;
    localparam logic [31:0] ADDR_STATUS = 32'hfffff48c;

    localparam logic [15:0] RST_AWT = 16'hffff;
    localparam logic [15:0] RST_IDC = 16'haaaa;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // ****************************************
    // Field layout, one group per chip-select area
    // ****************************************
    localparam int AREA_STRIDE = 2;
    localparam int AWT_SU_BASE = 0;
    localparam int AWT_HD_BASE = 1;
    localparam int IDC_IDLE_BASE = 1;

    localparam int STAT_HOLD_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_SPLIT_BIT = 2;
    localparam int STAT_RMW_BIT = 3;

    // ****************************************
    // Requesters, highest priority first
    // ****************************************
    localparam int NUM_REQ = 3;
    localparam int REQ_DATA = 0;
    localparam int REQ_BRF = 1;
    localparam int REQ_SQF = 2;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP_WAIT,
        ST_FIRST,
        ST_HOLD_WAIT,
        ST_SECOND,
        ST_DATA_WAIT,
        ST_THIRD,
        ST_IDLE_STATE,
        ST_RELEASED
    } ebwih_state_t;

endpackage : ebwih_pkg

/* File: rtl/ebwih_ctrl.sv */
// External bus cycle controller: address waits, read idle state,
// bus release handshake and external bus arbitration.
// Assumes requesters hold a request until its done pulse.
//
// What this block does
// - Setup wait adds one clock before the first bus state.
// - Hold wait adds one clock after the first bus state.
// - Setup and hold waits are set separately for area 0 and 1.
// - Hold-wait bit 1 inserts the hold wait, 0 omits it.
// - Setup-wait bit 1 inserts the setup wait, 0 omits it.
// - Address wait register is 16 bits, resets to all ones.
// - Internal memories and peripherals never get address waits.
// - One idle state may follow the third bus state per area.
// - Idle state only in read cycles, never in writes.
// - Idle control register is 16 bits, resets to alternating ones.
// - Internal memories and peripherals never get an idle state.
// - While release is requested the bus floats; driving resumes after.
// - Release acknowledge goes low while the bus is released.
// - Internal accesses continue during release; external ones stall.
// - No release between parts of split or read-modify-write accesses.
// - Clock-stopped modes never enter bus release.
// - In halt, acknowledge follows the request both ways.
// - Priority: release, operand data, branch fetch, successive fetch.
// - Fetch may split a read-modify-write, nothing may split a split.
`timescale 1ns/10ps
`default_nettype none

module ebwih_ctrl #(
    parameter int NUM_AREAS = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [31:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Operand data access
    input wire logic data_req_i,
    input wire logic data_wr_i,
    input wire logic data_ext_i,
    input wire logic data_area_i,
    input wire logic data_split_more_i,
    input wire logic data_rmw_read_i,
    output logic data_done_o,
    // Branch fetch
    input wire logic brf_req_i,
    input wire logic brf_ext_i,
    input wire logic brf_area_i,
    output logic brf_done_o,
    // Successive fetch
    input wire logic sqf_req_i,
    input wire logic sqf_ext_i,
    input wire logic sqf_area_i,
    output logic sqf_done_o,
    // Data wait request from the wait logic
    input wire logic data_wait_i,
    // Power modes
    input wire logic halt_i,
    input wire logic clk_stopped_i,
    // Pins
    input wire logic bus_release_request_n_i,
    output logic bus_release_ack_n_o,
    output logic bus_drive_o,
    output logic [NUM_AREAS-1:0] chip_select_n_o,
    output logic bus_read_o,
    output logic first_bus_state_o
);

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] awt_q;
    logic [15:0] idc_q;
    logic [15:0] status;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awt_q <= ebwih_pkg::RST_AWT;
            idc_q <= ebwih_pkg::RST_IDC;
        end else if (reg_wr_i) begin
            // Fixed bits are stored as written; they steer nothing
            if (reg_addr_i == ebwih_pkg::ADDR_AWT) begin
                awt_q <= reg_wdata_i;
            end
            if (reg_addr_i == ebwih_pkg::ADDR_IDC) begin
                idc_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= ebwih_pkg::REG_ZERO;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ebwih_pkg::ADDR_AWT: reg_rdata_o <= awt_q;
                ebwih_pkg::ADDR_IDC: reg_rdata_o <= idc_q;
                ebwih_pkg::ADDR_STATUS: reg_rdata_o <= status;
                default: reg_rdata_o <= ebwih_pkg::REG_ZERO;
            endcase
        end else begin
            reg_rdata_o <= ebwih_pkg::REG_ZERO;
        end
    end

    // ****************************************
    // Release request synchroniser
    // ****************************************
    logic rel_meta_q;
    logic rel_req_n_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rel_meta_q <= 1'b1;
            rel_req_n_q <= 1'b1;
        end else begin
            rel_meta_q <= bus_release_request_n_i;
            rel_req_n_q <= rel_meta_q;
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    ebwih_pkg::ebwih_state_t state_q;
    logic split_lock_q;
    logic rmw_lock_q;
    logic [ebwih_pkg::NUM_REQ-1:0] done_q;
    logic [ebwih_pkg::NUM_REQ-1:0] req;
    logic [ebwih_pkg::NUM_REQ-1:0] ext;
    logic [ebwih_pkg::NUM_REQ-1:0] area;
    logic [ebwih_pkg::NUM_REQ-1:0] eligible;
    logic [ebwih_pkg::NUM_REQ-1:0] grant;
    logic release_ok;
    logic take_release;
    logic take_ext;
    logic take_int;
    logic sel_area;
    logic sel_wr;

    assign req = {sqf_req_i, brf_req_i, data_req_i};
    assign ext = {sqf_ext_i, brf_ext_i, data_ext_i};
    assign area = {sqf_area_i, brf_area_i, data_area_i};

    // Halt needs no special path: with no CPU traffic the request wins at once
    assign release_ok = !rel_req_n_q && !clk_stopped_i
        && !split_lock_q && !rmw_lock_q;
    assign take_release = (state_q == ebwih_pkg::ST_IDLE) && release_ok;

    always_comb begin
        eligible = '0;
        for (int i = 0; i < ebwih_pkg::NUM_REQ; i++) begin
            // Internal targets proceed in idle or released state without the bus
            eligible[i] = req[i] && (done_q == '0)
                && (!ext[i] || ((state_q == ebwih_pkg::ST_IDLE) && !take_release));
        end
        if (split_lock_q) begin
            eligible[ebwih_pkg::REQ_BRF] = 1'b0;
            eligible[ebwih_pkg::REQ_SQF] = 1'b0;
        end
        // All requests wait while an external bus cycle is in progress
        if (state_q != ebwih_pkg::ST_IDLE && state_q != ebwih_pkg::ST_RELEASED) begin
            eligible = '0;
        end
    end

    always_comb begin
        grant = '0;
        for (int i = ebwih_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end

    assign take_ext = |(grant & ext);
    assign take_int = |(grant & ~ext);
    assign sel_area = |(grant & area);
    assign sel_wr = grant[ebwih_pkg::REQ_DATA] && data_wr_i;

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    logic [ebwih_pkg::NUM_REQ-1:0] owner_q;
    logic area_q;
    logic wr_q;
    logic hold_wait_q;
    logic idle_en_q;
    logic setup_sel;
    logic finish_ext;

    // Per-area enables picked from the chosen area's field group
    assign setup_sel = awt_q[ebwih_pkg::AWT_SU_BASE
        + ebwih_pkg::AREA_STRIDE * int'(sel_area)];

    assign finish_ext = (state_q == ebwih_pkg::ST_IDLE_STATE)
        || ((state_q == ebwih_pkg::ST_THIRD) && !(idle_en_q && !wr_q));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ebwih_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                ebwih_pkg::ST_IDLE: begin
                    if (take_release) begin
                        state_q <= ebwih_pkg::ST_RELEASED;
                    end else if (take_ext) begin
                        state_q <= setup_sel ? ebwih_pkg::ST_SETUP_WAIT
                            : ebwih_pkg::ST_FIRST;
                    end
                end
                ebwih_pkg::ST_SETUP_WAIT: state_q <= ebwih_pkg::ST_FIRST;
                ebwih_pkg::ST_FIRST: begin
                    state_q <= hold_wait_q ? ebwih_pkg::ST_HOLD_WAIT
                        : ebwih_pkg::ST_SECOND;
                end
                ebwih_pkg::ST_HOLD_WAIT: state_q <= ebwih_pkg::ST_SECOND;
                ebwih_pkg::ST_SECOND, ebwih_pkg::ST_DATA_WAIT: begin
                    state_q <= data_wait_i ? ebwih_pkg::ST_DATA_WAIT
                        : ebwih_pkg::ST_THIRD;
                end
                ebwih_pkg::ST_THIRD: begin
                    // Float delay of the memory only matters on reads
                    state_q <= (idle_en_q && !wr_q) ? ebwih_pkg::ST_IDLE_STATE
                        : ebwih_pkg::ST_IDLE;
                end
                ebwih_pkg::ST_IDLE_STATE: state_q <= ebwih_pkg::ST_IDLE;
                ebwih_pkg::ST_RELEASED: begin
                    if (rel_req_n_q) begin
                        state_q <= ebwih_pkg::ST_IDLE;
                    end
                end
                default: state_q <= ebwih_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            owner_q <= '0;
            area_q <= 1'b0;
            wr_q <= 1'b0;
            hold_wait_q <= 1'b0;
            idle_en_q <= 1'b0;
        end else if (take_ext) begin
            owner_q <= grant;
            area_q <= sel_area;
            wr_q <= sel_wr;
            hold_wait_q <= awt_q[ebwih_pkg::AWT_HD_BASE
                + ebwih_pkg::AREA_STRIDE * int'(sel_area)];
            idle_en_q <= idc_q[ebwih_pkg::IDC_IDLE_BASE
                + ebwih_pkg::AREA_STRIDE * int'(sel_area)];
        end
    end

    // Internal targets finish one cycle after being taken, no bus states
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= '0;
        end else if (take_int) begin
            done_q <= grant;
        end else if (finish_ext) begin
            done_q <= owner_q;
        end else begin
            done_q <= '0;
        end
    end

    assign data_done_o = done_q[ebwih_pkg::REQ_DATA];
    assign brf_done_o = done_q[ebwih_pkg::REQ_BRF];
    assign sqf_done_o = done_q[ebwih_pkg::REQ_SQF];

    // Locks set when a part is taken, cleared when the last part is taken
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            split_lock_q <= 1'b0;
            rmw_lock_q <= 1'b0;
        end else if (grant[ebwih_pkg::REQ_DATA]) begin
            split_lock_q <= data_split_more_i;
            rmw_lock_q <= data_rmw_read_i;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_release_ack_n_o <= 1'b1;
            bus_drive_o <= 1'b1;
        end else begin
            bus_release_ack_n_o <= !(take_release
                || (state_q == ebwih_pkg::ST_RELEASED && !rel_req_n_q));
            bus_drive_o <= !(take_release
                || (state_q == ebwih_pkg::ST_RELEASED && !rel_req_n_q));
        end
    end

    logic in_cycle_d;
    assign in_cycle_d = (take_ext && !take_release)
        || (state_q inside {ebwih_pkg::ST_SETUP_WAIT, ebwih_pkg::ST_FIRST,
            ebwih_pkg::ST_HOLD_WAIT, ebwih_pkg::ST_SECOND,
            ebwih_pkg::ST_DATA_WAIT});

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_select_n_o <= '1;
            bus_read_o <= 1'b0;
        end else begin
            chip_select_n_o <= '1;
            bus_read_o <= 1'b0;
            if (in_cycle_d) begin
                chip_select_n_o[take_ext ? sel_area : area_q] <= 1'b0;
                bus_read_o <= !(take_ext ? sel_wr : wr_q);
            end
        end
    end

    assign first_bus_state_o = (state_q == ebwih_pkg::ST_FIRST);

    always_comb begin
        status = ebwih_pkg::REG_ZERO;
        status[ebwih_pkg::STAT_HOLD_BIT] = (state_q == ebwih_pkg::ST_RELEASED);
        status[ebwih_pkg::STAT_BUSY_BIT] = (state_q != ebwih_pkg::ST_IDLE)
            && (state_q != ebwih_pkg::ST_RELEASED);
        status[ebwih_pkg::STAT_SPLIT_BIT] = split_lock_q;
        status[ebwih_pkg::STAT_RMW_BIT] = rmw_lock_q;
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_setup_wait_first: assert property (
        (state_q == ebwih_pkg::ST_IDLE && take_ext && !take_release && setup_sel)
        |=> state_q == ebwih_pkg::ST_SETUP_WAIT ##1 state_q == ebwih_pkg::ST_FIRST)
        else $error("setup wait not placed before first state");
    a_no_setup_wait: assert property (
        (state_q == ebwih_pkg::ST_IDLE && take_ext && !take_release && !setup_sel)
        |=> state_q == ebwih_pkg::ST_FIRST)
        else $error("setup wait inserted while disabled");
    a_hold_wait_after: assert property (
        (state_q == ebwih_pkg::ST_FIRST)
        |=> (state_q == ebwih_pkg::ST_HOLD_WAIT) == $past(hold_wait_q))
        else $error("hold wait does not follow its enable");
    a_idle_read_only: assert property (
        state_q == ebwih_pkg::ST_IDLE_STATE |-> !wr_q && $past(state_q == ebwih_pkg::ST_THIRD))
        else $error("idle state in a write or out of order");
    a_idle_after_read: assert property (
        (state_q == ebwih_pkg::ST_THIRD && idle_en_q && !wr_q)
        |=> state_q == ebwih_pkg::ST_IDLE_STATE ##1 state_q == ebwih_pkg::ST_IDLE)
        else $error("idle state missing after read");
    a_internal_no_wait: assert property (
        take_int |=> (done_q == $past(grant)) && chip_select_n_o == '1)
        else $error("internal access not done next cycle");
    a_ack_float_tie: assert property (
        !bus_release_ack_n_o |-> !bus_drive_o && state_q == ebwih_pkg::ST_RELEASED)
        else $error("bus driven during release");
    a_no_release_split: assert property (
        $fell(bus_release_ack_n_o) |-> $past(!split_lock_q && !rmw_lock_q))
        else $error("release granted inside a locked sequence");
    a_no_release_stopped: assert property (
        (state_q == ebwih_pkg::ST_IDLE && clk_stopped_i) |=> bus_release_ack_n_o)
        else $error("release entered with clock stopped");
    a_release_exit: assert property (
        (state_q == ebwih_pkg::ST_RELEASED && rel_req_n_q)
        |=> bus_release_ack_n_o && state_q == ebwih_pkg::ST_IDLE)
        else $error("release not left after request drops");
    a_halt_ack_follow: assert property (
        halt_i && take_release |=> !bus_release_ack_n_o) else $error("halt release not taken");
    a_data_priority: assert property (
        (eligible[ebwih_pkg::REQ_DATA]) |-> grant[ebwih_pkg::REQ_DATA])
        else $error("operand access lost to a fetch");
    a_split_no_fetch: assert property (
        split_lock_q |-> !grant[ebwih_pkg::REQ_BRF] && !grant[ebwih_pkg::REQ_SQF])
        else $error("fetch placed inside a split access");

    c_release_cycle: cover property (
        $fell(bus_release_ack_n_o) ##[1:20] $rose(bus_release_ack_n_o));
    c_full_read: cover property (
        state_q == ebwih_pkg::ST_SETUP_WAIT ##1 state_q == ebwih_pkg::ST_FIRST
        ##1 state_q == ebwih_pkg::ST_HOLD_WAIT ##[2:10] state_q == ebwih_pkg::ST_IDLE_STATE);
    c_fetch_in_rmw: cover property (rmw_lock_q && grant[ebwih_pkg::REQ_SQF]);
    c_internal_in_release: cover property (
        state_q == ebwih_pkg::ST_RELEASED && take_int);

endmodule : ebwih_ctrl

`default_nettype wire

/* File: test/ebwih_partner.sv */
// Far-side model: a second bus master and a slow external memory.
// Assumes it shares the system clock with the bus cycle controller.
`timescale 1ns/10ps
`default_nettype none

module ebwih_partner (
    input wire logic clock_i,
    input wire logic first_bus_state_i,
    output logic bus_release_request_n_o,
    output logic data_wait_o
);
    // ****************************************
    // Slow memory
    // ****************************************
    int n_wait = 0;
    int since_first = 99;

    // Stretches the cycle by n_wait data waits after the first state
    always @(posedge clock_i) begin
        since_first <= first_bus_state_i ? 0 : (since_first < 99 ? since_first + 1 : 99);
    end
    assign data_wait_o = since_first < n_wait;

    // ****************************************
    // Second bus master
    // ****************************************
    initial bus_release_request_n_o = 1'h1;

    task grab();
        @(posedge clock_i);
        bus_release_request_n_o <= 1'h0;
    endtask

    task free();
        @(posedge clock_i);
        bus_release_request_n_o <= 1'h1;
    endtask
endmodule // ebwih_partner

`default_nettype wire

/* File: test/ext_bus_wait_idle_hold_test.sv */
// Self-checking bench for the external bus cycle controller.
// Assumes the far-side model in ebwih_partner and a 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module ext_bus_wait_idle_hold_test;
    // ****************************************
    // Signals
    // ****************************************
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [31:0] reg_addr_i = 32'h0;
    logic [15:0] reg_wdata_i = 16'h0;
    logic reg_wr_i = 1'h0, reg_rd_i = 1'h0;
    logic [15:0] reg_rdata_o, rd;
    logic data_req_i = 1'h0, data_wr_i = 1'h0, data_ext_i = 1'h0, data_area_i = 1'h0;
    logic data_split_more_i = 1'h0, data_rmw_read_i = 1'h0, halt_i = 1'h0, clk_stopped_i = 1'h0;
    logic brf_req_i = 1'h0, brf_ext_i = 1'h1, brf_area_i = 1'h0;
    logic sqf_req_i = 1'h0, sqf_ext_i = 1'h1, sqf_area_i = 1'h0;
    logic data_done_o, brf_done_o, sqf_done_o, data_wait, req_n, ack_n, drive, rd_cyc, first;
    logic [1:0] cs_n;
    logic brf_seen = 1'h0, ack_low = 1'h0;
    int n_errors = 0, checked = 0, cycles = 0;

    ebwih_ctrl i_ebwih_ctrl (.clk_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .data_req_i(data_req_i), .data_wr_i(data_wr_i),
        .data_ext_i(data_ext_i), .data_area_i(data_area_i),
        .data_split_more_i(data_split_more_i), .data_rmw_read_i(data_rmw_read_i),
        .data_done_o(data_done_o), .brf_req_i(brf_req_i), .brf_ext_i(brf_ext_i),
        .brf_area_i(brf_area_i), .brf_done_o(brf_done_o), .sqf_req_i(sqf_req_i),
        .sqf_ext_i(sqf_ext_i), .sqf_area_i(sqf_area_i), .sqf_done_o(sqf_done_o),
        .data_wait_i(data_wait), .halt_i(halt_i), .clk_stopped_i(clk_stopped_i),
        .bus_release_request_n_i(req_n), .bus_release_ack_n_o(ack_n), .bus_drive_o(drive),
        .chip_select_n_o(cs_n), .bus_read_o(rd_cyc), .first_bus_state_o(first));

    ebwih_partner i_ebwih_partner (.clock_i(clock_i), .first_bus_state_i(first),
        .bus_release_request_n_o(req_n), .data_wait_o(data_wait));

    always #25 clock_i = ~clock_i;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clock_i) begin
        cycles++;
        if (brf_done_o === 1'h1) brf_seen <= 1'h1;
        if (ack_n === 1'h0) ack_low <= 1'h1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task reg_write(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'h0;
    endtask

    task reg_read(input logic [31:0] a, output logic [15:0] d);
        @(posedge clock_i);
        reg_rd_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'h0;
        #1 d = reg_rdata_o;
    endtask

    task wait_done(output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
            if (first === 1'h1) begin
                check(cs_n[data_area_i], 1'h0, "select in first state");
                check(rd_cyc, !data_wr_i, "read flag");
            end
        end while (data_done_o !== 1'h1 && n < 60);
    endtask

    // Split parts keep the request up into the next part
    task data_access(input logic wr, ext, area, split, input int exp, input string what);
        int n;
        @(posedge clock_i);
        data_req_i <= 1'h1;
        data_wr_i <= wr;
        data_ext_i <= ext;
        data_area_i <= area;
        data_split_more_i <= split;
        wait_done(n);
        check(16'(n), 16'(exp), what);
        if (!split) begin
            @(posedge clock_i);
            data_req_i <= 1'h0;
        end
    endtask

    // Fresh reset first, then both wait registers are written with the new values
    task set_waits(input logic [15:0] awt, input logic [15:0] idc);
        @(posedge clock_i);
        rst_n_i <= 1'h0;
        @(posedge clock_i);
        rst_n_i <= 1'h1;
        reg_write(ebwih_pkg::ADDR_AWT, awt);
        reg_write(ebwih_pkg::ADDR_IDC, idc);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        reg_read(ebwih_pkg::ADDR_AWT, rd);
        check(rd, 16'hffff, "address wait reset");
        reg_read(ebwih_pkg::ADDR_IDC, rd);
        check(rd, 16'haaaa, "idle control reset");
        reg_read(32'hfffff490, rd);
        check(rd, 16'h0000, "unmapped read");
        reg_write(ebwih_pkg::ADDR_AWT, 16'hff05);
        reg_read(ebwih_pkg::ADDR_AWT, rd);
        check(rd, 16'hff05, "address wait readback");
        $display("test reset_values done");
    endtask

    task t_waits();
        logic [15:0] awt [7] = '{16'hffff, 16'hffff, 16'hff01, 16'hff01, 16'hff08, 16'hff08, 16'hffff};
        logic [15:0] idc [7] = '{16'haaaa, 16'haaaa, 16'haaa8, 16'haaa8, 16'haaa8, 16'haaa8, 16'haaaa};
        logic area [7] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
        logic wr [7] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
        logic ext [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
        int exp [7] = '{7, 6, 5, 5, 4, 6, 1};
        for (int i = 0; i < 7; i++) begin
            set_waits(awt[i], idc[i]);
            data_access(wr[i], ext[i], area[i], 1'h0, exp[i], "cycle length");
        end
        $display("test address_waits_idle done");
    endtask

    task t_slow();
        set_waits(16'hff00, 16'haaa0);
        i_ebwih_partner.n_wait = 2;
        data_access(1'h0, 1'h1, 1'h0, 1'h0, 6, "slow memory");
        i_ebwih_partner.n_wait = 0;
        $display("test slow_memory done");
    endtask

    task t_priority();
        logic [15:0] ord [3] = '{16'hf, 16'hf, 16'hf};
        int k;
        logic [2:0] dn = 3'h0;
        k = 0;
        @(posedge clock_i);
        data_req_i <= 1'h1;
        data_ext_i <= 1'h1;
        data_wr_i <= 1'h0;
        data_area_i <= 1'h0;
        brf_req_i <= 1'h1;
        sqf_req_i <= 1'h1;
        repeat (40) begin
            @(posedge clock_i);
            // Drop at the edge that ends the done cycle
            if (dn[0]) data_req_i <= 1'h0;
            if (dn[1]) brf_req_i <= 1'h0;
            if (dn[2]) sqf_req_i <= 1'h0;
            #1 dn = {sqf_done_o === 1'h1, brf_done_o === 1'h1, data_done_o === 1'h1};
            if (dn[0] && k < 3) ord[k++] = 16'h0;
            if (dn[1] && k < 3) ord[k++] = 16'h1;
            if (dn[2] && k < 3) ord[k++] = 16'h2;
        end
        for (int i = 0; i < 3; i++) check(ord[i], 16'(i), "grant order");
        $display("test priority done");
    endtask

    task t_release();
        int n;
        i_ebwih_partner.grab();
        repeat (3) @(posedge clock_i);
        #1 check(ack_n, 1'h0, "release ack");
        check(drive, 1'h0, "bus floats");
        data_access(1'h0, 1'h0, 1'h0, 1'h0, 1, "internal during release");
        @(posedge clock_i);
        data_req_i <= 1'h1;
        data_ext_i <= 1'h1;
        n = 0;
        repeat (8) @(posedge clock_i) #1 if (data_done_o === 1'h1) n++;
        check(16'(n), 16'h0, "external stalls");
        reg_read(ebwih_pkg::ADDR_STATUS, rd);
        check(rd, 16'h0001, "status shows release");
        i_ebwih_partner.free();
        repeat (3) @(posedge clock_i);
        #1 check(ack_n, 1'h1, "ack back");
        check(drive, 1'h1, "bus driven again");
        wait_done(n);
        check(data_done_o, 1'h1, "stalled access completes");
        @(posedge clock_i);
        data_req_i <= 1'h0;
        $display("test bus_release done");
    endtask

    task t_modes();
        @(posedge clock_i);
        halt_i <= 1'h1;
        i_ebwih_partner.grab();
        repeat (3) @(posedge clock_i);
        #1 check(ack_n, 1'h0, "halt ack");
        i_ebwih_partner.free();
        repeat (3) @(posedge clock_i);
        #1 check(ack_n, 1'h1, "halt ack cleared");
        @(posedge clock_i);
        halt_i <= 1'h0;
        clk_stopped_i <= 1'h1;
        i_ebwih_partner.grab();
        repeat (8) @(posedge clock_i);
        #1 check(ack_n, 1'h1, "no release when stopped");
        check(drive, 1'h1, "bus kept when stopped");
        i_ebwih_partner.free();
        repeat (4) @(posedge clock_i);
        clk_stopped_i <= 1'h0;
        $display("test power_modes done");
    endtask

    task t_split();
        int n;
        ack_low <= 1'h0;
        brf_seen <= 1'h0;
        fork
            data_access(1'h0, 1'h1, 1'h0, 1'h1, 4, "split part one");
            begin
                // Fetch raised with the first part so that data wins the bus
                @(posedge clock_i);
                brf_req_i <= 1'h1;
                @(posedge clock_i);
                i_ebwih_partner.grab();
            end
        join
        data_access(1'h0, 1'h1, 1'h0, 1'h0, 4, "split part two");
        check(ack_low, 1'h0, "no release inside split");
        check(brf_seen, 1'h0, "no fetch inside split");
        repeat (4) @(posedge clock_i);
        #1 check(ack_n, 1'h0, "release before fetch");
        i_ebwih_partner.free();
        n = 0;
        while (brf_done_o !== 1'h1 && n < 40) begin
            @(posedge clock_i);
            #1 n++;
        end
        check(brf_done_o, 1'h1, "fetch after release");
        @(posedge clock_i);
        brf_req_i <= 1'h0;
        $display("test split_lock done");
    endtask

    // ****************************************
    // Sequence and verdict
    // ****************************************
    task complete_run();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'h1;
        t_reset();
        t_waits();
        t_slow();
        t_priority();
        t_release();
        t_modes();
        t_split();
        complete_run();
    end
endmodule // ext_bus_wait_idle_hold_test

`default_nettype wire
